/* common/gma_params.svh */
// Register indices, field masks and field layouts of the memory-area bank
`ifndef GMA_PARAMS_SVH
`define GMA_PARAMS_SVH

// ****************************************
// Register indices (word index on the register port)
// ****************************************
`define GMA_IDX_LIST_HI 5'h00
`define GMA_IDX_LIST_LO 5'h01
`define GMA_IDX_SOURCE 5'h02
`define GMA_IDX_WORK 5'h03
`define GMA_IDX_DEST_HI 5'h04
`define GMA_IDX_DEST_LO 5'h05
`define GMA_IDX_COUNT 5'h06
`define GMA_IDX_SYSCTL 5'h07
`define GMA_IDX_CONV 5'h08
`define GMA_IDX_ISTORE 5'h09
`define GMA_IDX_WIDTH 5'h0a
`define GMA_IDX_HEIGHT 5'h0b
`define GMA_IDX_HOST_STAT 5'h1f

// ****************************************
// Writable field masks; all other bits are reserved
// ****************************************
`define GMA_MASK_LIST_HI 16'h007f
`define GMA_MASK_LIST_LO 16'hffe0
`define GMA_MASK_SOURCE 16'h007e
`define GMA_MASK_WORK 16'h007f
`define GMA_MASK_DEST_HI 16'h007f
`define GMA_MASK_DEST_LO 16'hfffe
`define GMA_MASK_FULL 16'hffff
`define GMA_MASK_MODE 16'h0003

// ****************************************
// Field positions
// ****************************************
`define GMA_LIST_HI_MSB 6
`define GMA_LIST_LO_MSB 15
`define GMA_LIST_LO_LSB 5
`define GMA_SOURCE_MSB 6
`define GMA_SOURCE_LSB 1
`define GMA_WORK_MSB 6
`define GMA_DEST_HI_MSB 6
`define GMA_DEST_LO_MSB 15
`define GMA_DEST_LO_LSB 1
`define GMA_MODE_MSB 1
`define GMA_ISTORE_PAD 6'h00
`define GMA_CONV_NORMAL 2'h0
`define GMA_STAT_BUSY 0
`define GMA_STAT_REFUSED 1

`endif

/* common/gma_pkg.sv */
// Types shared by both ends of the memory-area bank
package gma_pkg;

  // ****************************************
  // Host transfer mode held in the system control register
  // ****************************************
  typedef enum logic [1:0] {
    GMA_XFER_IDLE = 2'b00,
    GMA_XFER_RSVD = 2'b01,
    GMA_XFER_STORE = 2'b10,
    GMA_XFER_CONVERT = 2'b11
  } gma_xfer_mode_t;

  // ****************************************
  // Device state cleared by reset
  // ****************************************
  typedef struct packed {
    logic [6:0] dest_hi;
    logic [14:0] dest_lo;
    logic [15:0] count;
    gma_xfer_mode_t mode;
    logic [21:0] ptr;
    logic [31:0] rem;
    logic pend;
    logic [21:0] maddr;
    logic [15:0] mdata;
    logic rdy;
    logic [15:0] rdata;
    logic active;
  } gma_dev_state_t;

  // ****************************************
  // Device state that survives reset
  // ****************************************
  typedef struct packed {
    logic [6:0] list_hi;
    logic [10:0] list_lo;
    logic [5:0] source;
    logic [6:0] work;
    logic [1:0] conv;
    logic [15:0] istore;
    logic [15:0] width;
    logic [15:0] height;
  } gma_dev_keep_t;

endpackage : gma_pkg

/* common/gma_if.sv */
// Link between the host controller and the memory-area bank
`timescale 1ns/1ps
interface gma_if;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic [15:0] dat;
  logic dat_valid;
  logic dat_ready;
  logic xfer_active;

  modport dev (
    input reg_addr, reg_wdata, reg_wr, reg_rd, dat, dat_valid,
    output reg_rdata, dat_ready, xfer_active
  );

  modport host (
    output reg_addr, reg_wdata, reg_wr, reg_rd, dat, dat_valid,
    input reg_rdata, dat_ready, xfer_active
  );
endinterface : gma_if

/* core/gma_device.sv */
// Memory-area configuration and transfer setup bank of the graphics core
//
// How it works
// - List start: 18 bits, address A22..A5
// - Source area: bits 6..1 give A22..A17
// - Work area: bits 6..0 give A22..A16
// - Destination: high A22..A16, low A15..A1
// - Destination is a 16-bit word address
// - Write zeros to reserved; reads undefined
// - Area start fields survive reset
// - Host leaves destination alone in mode 10
// - Mode 11 ignores destination registers
// - Mode 11 stores from image start onward
// - Reset clears destination fields
// - Word count counts 16-bit words
// - Host leaves count alone while active
// - Host matches count to image size
// - Mismatch stops at smaller; clears both modes
// - Reset clears the word count
// - Pixel total counts down; clears convert mode
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "gma_params.svh"

module gma_device
  import gma_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  gma_if.dev bus,
  output logic o_mem_we,
  output logic [21:0] o_mem_addr,
  output logic [15:0] o_mem_data,
  input wire logic i_mem_ready,
  output logic [17:0] o_list_start,
  output logic [5:0] o_source_start,
  output logic [6:0] o_work_start,
  output logic [1:0] o_conv_mode
);

  // ****************************************
  // State
  // ****************************************
  gma_dev_state_t q_ff;
  gma_dev_state_t nxt_q;
  gma_dev_keep_t k_ff;
  gma_dev_keep_t nxt_k;
  logic acc;
  logic wr_hit;
  logic [31:0] pix_total;
  logic [31:0] word_total;

  // True while a host transfer mode moves data
  function automatic logic mode_moves(input gma_xfer_mode_t m);
    return (m == GMA_XFER_STORE) || (m == GMA_XFER_CONVERT);
  endfunction : mode_moves

  // Smaller of two totals, so a mismatch ends early
  function automatic logic [31:0] min32(input logic [31:0] a,
                                        input logic [31:0] b);
    return (a < b) ? a : b;
  endfunction : min32

  // ****************************************
  // Handshake terms
  // ****************************************
  // A word is taken only while ready is up and nothing is pending
  assign acc = q_ff.rdy && bus.dat_valid;
  assign wr_hit = bus.reg_wr;
  // One pixel per 16-bit word in this build
  assign pix_total = 32'(k_ff.width) * 32'(k_ff.height);
  assign word_total = {16'h0000, q_ff.count};

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    nxt_q = q_ff;
    nxt_k = k_ff;

    // Memory side takes the pending word when it is ready
    if (q_ff.pend && i_mem_ready) begin
      nxt_q.pend = 1'b0;
    end

    // Incoming word goes to the next word address
    if (acc) begin
      nxt_q.pend = 1'b1;
      nxt_q.maddr = q_ff.ptr;
      nxt_q.mdata = bus.dat;
      nxt_q.ptr = q_ff.ptr + 22'h00_0001;
      nxt_q.rem = q_ff.rem - 32'h0000_0001;
      if (q_ff.rem == 32'h0000_0001) begin
        // Last word: mode goes idle; the conversion field falls back to normal only in mode 11
        nxt_q.mode = GMA_XFER_IDLE;
        if (q_ff.mode == GMA_XFER_CONVERT) begin
          nxt_k.conv = `GMA_CONV_NORMAL;
        end
      end
    end

    // Register writes; reserved bits are dropped on the way in
    if (wr_hit) begin
      unique case (bus.reg_addr)
        `GMA_IDX_LIST_HI: begin
          nxt_k.list_hi = bus.reg_wdata[`GMA_LIST_HI_MSB:0];
        end
        `GMA_IDX_LIST_LO: begin
          nxt_k.list_lo =
            bus.reg_wdata[`GMA_LIST_LO_MSB:`GMA_LIST_LO_LSB];
        end
        `GMA_IDX_SOURCE: begin
          nxt_k.source =
            bus.reg_wdata[`GMA_SOURCE_MSB:`GMA_SOURCE_LSB];
        end
        `GMA_IDX_WORK: begin
          nxt_k.work = bus.reg_wdata[`GMA_WORK_MSB:0];
        end
        `GMA_IDX_DEST_HI: begin
          nxt_q.dest_hi = bus.reg_wdata[`GMA_DEST_HI_MSB:0];
        end
        `GMA_IDX_DEST_LO: begin
          nxt_q.dest_lo =
            bus.reg_wdata[`GMA_DEST_LO_MSB:`GMA_DEST_LO_LSB];
        end
        `GMA_IDX_COUNT: begin
          nxt_q.count = bus.reg_wdata;
        end
        `GMA_IDX_SYSCTL: begin
          // A store or convert command restarts the pointer and the remaining count
          nxt_q.mode = gma_xfer_mode_t'(bus.reg_wdata[`GMA_MODE_MSB:0]);
          unique case (nxt_q.mode)
            GMA_XFER_STORE: begin
              nxt_q.ptr = {q_ff.dest_hi, q_ff.dest_lo};
              nxt_q.rem = word_total;
            end
            GMA_XFER_CONVERT: begin
              // Destination registers play no part here
              nxt_q.ptr = {k_ff.istore, `GMA_ISTORE_PAD};
              nxt_q.rem = min32(word_total, pix_total);
            end
            GMA_XFER_IDLE, GMA_XFER_RSVD: begin
              nxt_q.rem = 32'h0000_0000;
            end
          endcase
          // Nothing to move: the command ends at once
          if (mode_moves(nxt_q.mode) && nxt_q.rem == 32'h0000_0000) begin
            nxt_q.mode = GMA_XFER_IDLE;
          end
        end
        `GMA_IDX_CONV: begin
          nxt_k.conv = bus.reg_wdata[`GMA_MODE_MSB:0];
        end
        `GMA_IDX_ISTORE: begin
          nxt_k.istore = bus.reg_wdata;
        end
        `GMA_IDX_WIDTH: begin
          nxt_k.width = bus.reg_wdata;
        end
        `GMA_IDX_HEIGHT: begin
          nxt_k.height = bus.reg_wdata;
        end
        default: begin
          // Unmapped index: write is dropped
        end
      endcase
    end

    // Register reads; reserved bits read as zero
    if (bus.reg_rd) begin
      unique case (bus.reg_addr)
        `GMA_IDX_LIST_HI: nxt_q.rdata = {9'h000, k_ff.list_hi};
        `GMA_IDX_LIST_LO: nxt_q.rdata = {k_ff.list_lo, 5'h00};
        `GMA_IDX_SOURCE: nxt_q.rdata = {9'h000, k_ff.source, 1'b0};
        `GMA_IDX_WORK: nxt_q.rdata = {9'h000, k_ff.work};
        `GMA_IDX_DEST_HI: nxt_q.rdata = {9'h000, q_ff.dest_hi};
        `GMA_IDX_DEST_LO: nxt_q.rdata = {q_ff.dest_lo, 1'b0};
        `GMA_IDX_COUNT: nxt_q.rdata = q_ff.count;
        `GMA_IDX_SYSCTL: nxt_q.rdata = {14'h0000, q_ff.mode};
        `GMA_IDX_CONV: nxt_q.rdata = {14'h0000, k_ff.conv};
        `GMA_IDX_ISTORE: nxt_q.rdata = k_ff.istore;
        `GMA_IDX_WIDTH: nxt_q.rdata = k_ff.width;
        `GMA_IDX_HEIGHT: nxt_q.rdata = k_ff.height;
        default: nxt_q.rdata = 16'h0000;
      endcase
    end

    // Ready only with room; one word in flight keeps ordering simple
    nxt_q.active = mode_moves(nxt_q.mode);
    nxt_q.rdy = nxt_q.active && !nxt_q.pend &&
                (nxt_q.rem != 32'h0000_0000);
  end

  // ****************************************
  // Registers cleared by reset
  // ****************************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ****************************************
  // Area start fields hold their value across reset
  // ****************************************
  // No reset term: software must load these once after power-up
  always_ff @(posedge i_clk) begin
    k_ff <= nxt_k;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign bus.reg_rdata = q_ff.rdata;
  assign bus.dat_ready = q_ff.rdy;
  assign bus.xfer_active = q_ff.active;
  assign o_mem_we = q_ff.pend;
  assign o_mem_addr = q_ff.maddr;
  assign o_mem_data = q_ff.mdata;
  assign o_list_start = {k_ff.list_hi, k_ff.list_lo};
  assign o_source_start = k_ff.source;
  assign o_work_start = k_ff.work;
  assign o_conv_mode = k_ff.conv;

endmodule : gma_device

/* core/gma_host.sv */
// Host controller: register port bridge and buffered transfer source
`timescale 1ns/1ps
`include "gma_params.svh"

module gma_host
  import gma_pkg::*;
#(
  parameter int DEPTH = 2
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  gma_if.host bus,
  input wire logic [4:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic o_rdata_valid,
  input wire logic [15:0] i_data,
  input wire logic i_valid,
  output logic o_ready
);

  localparam int AW = $clog2(DEPTH);

  // ****************************************
  // Elaboration check
  // ****************************************
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("DEPTH must be a power of two, at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic rw2;
    logic lw1;
    logic lw2;
    logic [15:0] rdata;
    logic rvalid;
    logic refused;
    logic [DEPTH-1:0][15:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic dv;
    logic [15:0] dout;
    logic in_rdy;
  } gma_host_state_t;

  gma_host_state_t q_ff;
  gma_host_state_t nxt_q;
  logic busy;
  logic guarded;
  logic push;
  logic pop;

  // Writable bits of each register; reserved bits are sent as zero
  function automatic logic [15:0] field_mask(input logic [4:0] idx);
    unique case (idx)
      `GMA_IDX_LIST_HI: return `GMA_MASK_LIST_HI;
      `GMA_IDX_LIST_LO: return `GMA_MASK_LIST_LO;
      `GMA_IDX_SOURCE: return `GMA_MASK_SOURCE;
      `GMA_IDX_WORK: return `GMA_MASK_WORK;
      `GMA_IDX_DEST_HI: return `GMA_MASK_DEST_HI;
      `GMA_IDX_DEST_LO: return `GMA_MASK_DEST_LO;
      `GMA_IDX_SYSCTL, `GMA_IDX_CONV: return `GMA_MASK_MODE;
      default: return `GMA_MASK_FULL;
    endcase
  endfunction : field_mask

  // ****************************************
  // Guard terms
  // ****************************************
  // Covers the cycle before the device shows its active flag
  assign busy = bus.xfer_active ||
                (q_ff.wr && q_ff.addr == `GMA_IDX_SYSCTL &&
                 q_ff.wdata[`GMA_MODE_MSB]);
  assign guarded = i_addr == `GMA_IDX_DEST_HI ||
                   i_addr == `GMA_IDX_DEST_LO ||
                   i_addr == `GMA_IDX_COUNT;
  assign push = i_valid && q_ff.in_rdy;
  assign pop = q_ff.dv && bus.dat_ready;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    nxt_q = q_ff;
    nxt_q.wr = 1'b0;
    nxt_q.rd = 1'b0;
    nxt_q.lw1 = 1'b0;
    nxt_q.rvalid = 1'b0;

    // Forward orders; local status never reaches the device
    if (i_wr && i_addr != `GMA_IDX_HOST_STAT) begin
      if (busy && guarded) begin
        nxt_q.refused = 1'b1;
      end else begin
        nxt_q.wr = 1'b1;
        nxt_q.addr = i_addr;
        nxt_q.wdata = i_wdata & field_mask(i_addr);
      end
    end
    if (i_rd) begin
      nxt_q.addr = i_addr;
      nxt_q.rd = i_addr != `GMA_IDX_HOST_STAT;
      nxt_q.lw1 = i_addr == `GMA_IDX_HOST_STAT;
    end
    nxt_q.rw2 = q_ff.rd;
    nxt_q.lw2 = q_ff.lw1;

    // Answers line up at the same latency for both kinds
    if (q_ff.rw2) begin
      nxt_q.rdata = bus.reg_rdata;
      nxt_q.rvalid = 1'b1;
    end
    if (q_ff.lw2) begin
      nxt_q.rdata = 16'h0000;
      nxt_q.rdata[`GMA_STAT_BUSY] = bus.xfer_active;
      nxt_q.rdata[`GMA_STAT_REFUSED] = q_ff.refused;
      nxt_q.rvalid = 1'b1;
      // Clear on read; a refusal in the same cycle still sticks
      if (!(i_wr && busy && guarded && i_addr != `GMA_IDX_HOST_STAT)) begin
        nxt_q.refused = 1'b0;
      end
    end

    // DEPTH-entry buffer keeps words while the device stalls
    if (push) begin
      nxt_q.mem[q_ff.wp] = i_data;
      nxt_q.wp = q_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_q.rp = q_ff.rp + 1'b1;
    end
    nxt_q.cnt = q_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    nxt_q.dv = nxt_q.cnt != '0;
    nxt_q.dout = nxt_q.mem[nxt_q.rp];
    nxt_q.in_rdy = nxt_q.cnt != (AW+1)'(DEPTH);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign bus.reg_addr = q_ff.addr;
  assign bus.reg_wdata = q_ff.wdata;
  assign bus.reg_wr = q_ff.wr;
  assign bus.reg_rd = q_ff.rd;
  assign bus.dat = q_ff.dout;
  assign bus.dat_valid = q_ff.dv;
  assign o_rdata = q_ff.rdata;
  assign o_rdata_valid = q_ff.rvalid;
  assign o_ready = q_ff.in_rdy;

endmodule : gma_host

/* verif/gma_monitor.sv */
// Link checker for the memory-area bank
`timescale 1ns/1ps
`include "gma_params.svh"
module gma_monitor (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic dat_valid,
  input wire logic dat_ready,
  input wire logic xfer_active
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  logic [15:0] cnt_ff;
  logic [16:0] took_ff;
  // Words taken per transfer; counted so overrun shows up
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= 16'h0000;
      took_ff <= 17'h0_0000;
    end else begin
      if (reg_wr && reg_addr == `GMA_IDX_COUNT && !xfer_active) begin
        cnt_ff <= reg_wdata;
      end
      if (!xfer_active) begin
        took_ff <= 17'h0_0000;
      end else if (dat_valid && dat_ready) begin
        took_ff <= took_ff + 17'h0_0001;
      end
    end
  end
  // ****
  // Properties
  // ****
  property p_idle_no_take;
    !xfer_active |-> !dat_ready;
  endproperty
  property p_one_in_flight;
    dat_valid && dat_ready |=> !dat_ready;
  endproperty
  property p_cmd_starts;
    $rose(xfer_active) |-> $past(reg_wr) &&
      $past(reg_addr) == `GMA_IDX_SYSCTL;
  endproperty
  property p_mode_read;
    reg_rd && reg_addr == `GMA_IDX_SYSCTL |=>
      reg_rdata[1] == $past(xfer_active) && reg_rdata[15:2] == 14'h0000;
  endproperty
  property p_unmapped;
    reg_rd && reg_addr > 5'h0b |=> reg_rdata == 16'h0000;
  endproperty
  property p_source_rsvd;
    reg_rd && reg_addr == `GMA_IDX_SOURCE |=>
      (reg_rdata & ~`GMA_MASK_SOURCE) == 16'h0000;
  endproperty
  property p_readback;
    reg_wr && reg_addr == `GMA_IDX_DEST_LO && !xfer_active ##1 !reg_wr
      ##1 reg_rd && reg_addr == `GMA_IDX_DEST_LO |=>
      reg_rdata == ($past(reg_wdata, 3) & `GMA_MASK_DEST_LO);
  endproperty
  property p_count_bound;
    took_ff <= {1'b0, cnt_ff};
  endproperty
  a_idle_no_take: assert property (p_idle_no_take)
    else $error("stream taken while idle");
  a_one_in_flight: assert property (p_one_in_flight)
    else $error("ready held after a take");
  a_cmd_starts: assert property (p_cmd_starts)
    else $error("transfer began without a mode write");
  a_mode_read: assert property (p_mode_read)
    else $error("mode read disagrees with activity");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_source_rsvd: assert property (p_source_rsvd)
    else $error("source reserved bits not zero");
  a_readback: assert property (p_readback)
    else $error("destination low readback wrong");
  a_count_bound: assert property (p_count_bound)
    else $error("more words taken than counted");
  c_take: cover property (dat_valid && dat_ready);
  c_done: cover property ($fell(xfer_active));
  c_readback: cover property (p_readback);
endmodule : gma_monitor

/* verif/gma_bench.sv */
// Bench joining host and device ends of the memory-area bank
`timescale 1ns/1ps
`include "gma_params.svh"
module gma_bench;
  logic i_clk;
  logic i_rst_n;
  logic [4:0] i_addr;
  logic [15:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [15:0] i_data;
  logic i_valid;
  logic i_mem_ready;
  logic mem_slow;
  logic [1:0] cyc;
  logic [15:0] o_rdata;
  logic o_rdata_valid;
  logic o_ready;
  logic o_mem_we;
  logic [21:0] o_mem_addr;
  logic [15:0] o_mem_data;
  logic [17:0] o_list_start;
  logic [5:0] o_source_start;
  logic [6:0] o_work_start;
  logic [1:0] o_conv_mode;
  logic [37:0] memq[$];
  int errors;
  int n_tests;
  gma_if link ();
  gma_device gma_device_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .bus(link.dev), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
    .o_mem_data(o_mem_data), .i_mem_ready(i_mem_ready),
    .o_list_start(o_list_start), .o_source_start(o_source_start),
    .o_work_start(o_work_start), .o_conv_mode(o_conv_mode));
  gma_host #(.DEPTH(2)) gma_host_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .bus(link.host), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid),
    .i_data(i_data), .i_valid(i_valid), .o_ready(o_ready));
  gma_monitor gma_monitor_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
    .reg_wr(link.reg_wr), .reg_rd(link.reg_rd),
    .reg_rdata(link.reg_rdata), .dat_valid(link.dat_valid),
    .dat_ready(link.dat_ready), .xfer_active(link.xfer_active));
  // 10 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  // Memory side; slow mode stalls half the time to back up the buffer
  always @(posedge i_clk) begin
    cyc <= cyc + 2'd1;
    i_mem_ready <= !mem_slow || cyc[1];
    if (o_mem_we && i_mem_ready) begin
      memq.push_back({o_mem_addr, o_mem_data});
    end
  end
  // ****
  // Shared tasks
  // ****
  task automatic chk(input string s, input logic [37:0] e,
    input logic [37:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    chk("read valid", 38'h1, 38'(o_rdata_valid));
    chk("read data", 38'(e), 38'(o_rdata));
  endtask : rdc
  // Sampled at the falling edge so the take edge is never raced
  task automatic push(input logic [15:0] d);
    logic r;
    int n;
    @(posedge i_clk);
    i_valid <= 1'b1;
    i_data <= d;
    r = 1'b0;
    n = 0;
    while (!r && n < 300) begin
      @(negedge i_clk);
      r = (o_ready === 1'b1);
      @(posedge i_clk);
      n++;
    end
    i_valid <= 1'b0;
    chk("push taken", 38'h1, 38'(r));
  endtask : push
  task automatic mem_chk(input int n, input logic [21:0] a0,
    input logic [15:0] d0);
    int k;
    k = 0;
    while (memq.size() < n && k < 400) begin
      @(posedge i_clk);
      k++;
    end
    repeat (8) @(posedge i_clk);
    chk("stored words", 38'(n), 38'(memq.size()));
    k = 0;
    while (memq.size() > 0) begin
      chk("store word", {a0 + 22'(k), d0 + 16'(k)}, memq.pop_front());
      k++;
    end
  endtask : mem_chk
  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    rdc(`GMA_IDX_DEST_HI, 16'h0000);
    rdc(`GMA_IDX_DEST_LO, 16'h0000);
    rdc(`GMA_IDX_COUNT, 16'h0000);
    rdc(`GMA_IDX_SYSCTL, 16'h0000);
    rdc(5'h0c, 16'h0000);
    // Zero count ends a store at once; the spare code moves nothing
    wr(`GMA_IDX_SYSCTL, 16'h0002);
    rdc(`GMA_IDX_SYSCTL, 16'h0000);
    wr(`GMA_IDX_SYSCTL, 16'h0001);
    rdc(`GMA_IDX_SYSCTL, 16'h0001);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_fields;
    wr(`GMA_IDX_LIST_HI, 16'h0055);
    wr(`GMA_IDX_LIST_LO, 16'hace0);
    wr(`GMA_IDX_SOURCE, 16'h006a);
    wr(`GMA_IDX_WORK, 16'h0049);
    wr(`GMA_IDX_DEST_LO, 16'h7ffe);
    rdc(`GMA_IDX_DEST_LO, 16'h7ffe);
    rdc(`GMA_IDX_SOURCE, 16'h006a);
    for (int p = 0; p < 2; p++) begin
      chk("list", 38'({7'h55, 11'h567}), 38'(o_list_start));
      chk("source", 38'h35, 38'(o_source_start));
      chk("work", 38'h49, 38'(o_work_start));
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
      #1;
    end
    rdc(`GMA_IDX_DEST_LO, 16'h0000);
    $display("t_fields done");
  endtask : t_fields
  // Buffer fills while idle, drains under memory stalls
  task automatic t_store;
    wr(`GMA_IDX_DEST_HI, 16'h0012);
    wr(`GMA_IDX_DEST_LO, 16'h3456);
    wr(`GMA_IDX_COUNT, 16'h0003);
    mem_slow <= 1'b1;
    push(16'hc000);
    push(16'hc001);
    @(negedge i_clk);
    chk("buffer full", 38'h0, 38'(o_ready));
    wr(`GMA_IDX_SYSCTL, 16'h0002);
    wr(`GMA_IDX_DEST_LO, 16'h0000);
    push(16'hc002);
    mem_chk(3, 22'h09_1a2b, 16'hc000);
    rdc(`GMA_IDX_SYSCTL, 16'h0000);
    rdc(`GMA_IDX_DEST_LO, 16'h3456);
    // Refusal sticks until a status read clears it
    rdc(`GMA_IDX_HOST_STAT, 16'h0002);
    rdc(`GMA_IDX_HOST_STAT, 16'h0000);
    mem_slow <= 1'b0;
    $display("t_store done");
  endtask : t_store
  task automatic t_conv(input logic [15:0] c, input logic [15:0] w,
    input logic [15:0] h, input int xtra);
    int n;
    n = (int'(c) < int'(w) * int'(h)) ? int'(c) : int'(w) * int'(h);
    wr(`GMA_IDX_DEST_HI, 16'h0055);
    wr(`GMA_IDX_COUNT, c);
    wr(`GMA_IDX_WIDTH, w);
    wr(`GMA_IDX_HEIGHT, h);
    wr(`GMA_IDX_ISTORE, 16'h0003);
    wr(`GMA_IDX_CONV, 16'h0001);
    wr(`GMA_IDX_SYSCTL, 16'h0003);
    wr(`GMA_IDX_COUNT, 16'h0000);
    for (int i = 0; i < n + xtra; i++) begin
      push(16'h0a00 + 16'(i));
    end
    mem_chk(n, 22'h00_00c0, 16'h0a00);
    rdc(`GMA_IDX_SYSCTL, 16'h0000);
    rdc(`GMA_IDX_COUNT, c);
    chk("convert mode", 38'h0, 38'(o_conv_mode));
    $display("t_conv done");
  endtask : t_conv
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    errors = 0;
    n_tests = 0;
    i_rst_n = 1'b0;
    i_addr = 5'h00;
    i_wdata = 16'h0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_data = 16'h0000;
    i_valid = 1'b0;
    i_mem_ready = 1'b1;
    mem_slow = 1'b0;
    cyc = 2'd0;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset;
    t_fields;
    t_store;
    t_conv(16'h0005, 16'h0002, 16'h0001, 0);
    t_conv(16'h0004, 16'h0002, 16'h0002, 0);
    // Leaves one word in the host buffer, so it runs last
    t_conv(16'h0001, 16'h0002, 16'h0002, 1);
    end_of_test;
  end
  // Watchdog well beyond the few hundred cycles the run needs
  initial begin
    #3_000_000;
    errors++;
    $display("watchdog expired");
    end_of_test;
  end
endmodule : gma_bench
